// ==== logic/pfsm_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Pin function select and peripheral input source mux
module pfsm_top
   import pfsm_pkg::*;
#(
   parameter int unsigned VARIANT = 3
) (
   // Clock, reset and clock enable
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // APB slave
   input wire logic [PFSM_ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PFSM_DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [PFSM_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Package pin levels
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_b_in,
   input wire logic [7:0] port_c_in,
   input wire logic [7:0] port_d_in,
   input wire logic [7:0] port_e_in,
   input wire logic [7:0] port_f_in,
   input wire logic [7:0] port_g_in,
   input wire logic [7:0] port_h_in,
   input wire logic [7:0] port_j_in,
   // GPIO drive for ports H and J
   input wire logic [7:0] gpio_h_out,
   input wire logic [7:0] gpio_h_oe,
   input wire logic [7:0] gpio_j_out,
   input wire logic [7:0] gpio_j_oe,
   // Periodic timer outputs
   input wire logic periodic_timer4_out,
   input wire logic periodic_timer5_out,
   input wire logic periodic_timer6_out,
   input wire logic periodic_timer7_out,
   // Port H pin drive and analog or LCD hookup
   output logic [7:0] ph_pin_out,
   output logic [7:0] ph_pin_oe,
   output logic [7:0] ph_lcd_seg_en,
   output logic analog_channel_14_en,
   output logic analog_channel_15_en,
   // Port J pin drive and LCD hookup
   output logic [7:0] pj_pin_out,
   output logic [7:0] pj_pin_oe,
   output logic [7:0] pj_lcd_seg_en,
   output logic [3:0] pj_lcd_common_en,
   // Routed peripheral inputs
   output logic [7:0] periodic_timer_clock_in,
   output logic [7:0] periodic_timer_capture_in,
   output logic [2:0] standard_timer_clock_in,
   output logic [2:0] standard_timer_capture_in,
   output logic serial_select_in,
   output logic serial_data_in,
   output logic serial_clock_in,
   output logic [3:0] ext_irq_in,
   output logic [2:0] uart_receive_in
);
   // ==========================================================
   // Helper functions

   // Implemented bits of each selector register
   function automatic logic [7:0] reg_mask(input logic [PFSM_IDX_W-1:0] idx);
      logic [7:0] m;
      m = PFSM_MASK_NONE;
      unique case (idx)
         PFSM_IDX_PH_LOW: m = (VARIANT > PFSM_VAR_SMALL) ? PFSM_MASK_PH_LOW : PFSM_MASK_NONE;
         PFSM_IDX_PH_HIGH: m = (VARIANT > PFSM_VAR_SMALL) ? PFSM_MASK_ALL : PFSM_MASK_NONE;
         PFSM_IDX_PJ_LOW: m = PFSM_MASK_ALL;
         PFSM_IDX_PJ_HIGH: m = (VARIANT > PFSM_VAR_SMALL) ? PFSM_MASK_ALL : PFSM_MASK_PJ_HIGH_SMALL;
         PFSM_IDX_TCLK_SRC: m = PFSM_MASK_SRC_7BIT;
         PFSM_IDX_TCAP_SRC: m = PFSM_MASK_SRC_7BIT;
         PFSM_IDX_SER_SRC: m = PFSM_MASK_SRC_7BIT;
         PFSM_IDX_EXT_SRC: m = (VARIANT > PFSM_VAR_SMALL) ? PFSM_MASK_ALL : PFSM_MASK_NONE;
         PFSM_IDX_UART_SRC: m = (VARIANT >= PFSM_VAR_UART2) ? PFSM_MASK_UART_FULL : PFSM_MASK_UART_SMALL;
         default: m = PFSM_MASK_NONE;
      endcase
      return m;
   endfunction : reg_mask

   // True when a two-bit code leaves the pin as GPIO
   function automatic logic fn_is_gpio(input logic [1:0] code, input logic alt_is_gpio);
      return (code < PFSM_FN_ALT) || (alt_is_gpio && (code == PFSM_FN_ALT));
   endfunction : fn_is_gpio

   // ==========================================================
   // Reset release
   logic rst_meta_q;
   logic rst_sync_q;
   logic rst_n;

   // Asynchronous assert, two-flop release
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else if (clk_en) begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign rst_n = rst_sync_q;

   // ==========================================================
   // APB register file
   logic [7:0] cfg_q [PFSM_NUM_REGS];
   logic [PFSM_IDX_W-1:0] idx;
   logic mapped;
   logic setup_phase;
   logic write_take;
   logic [7:0] wr_mask;
   logic [PFSM_DATA_W-1:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   // Address decode
   assign idx = paddr[PFSM_IDX_W+1:2];
   assign mapped = (paddr[PFSM_ADDR_W-1:PFSM_IDX_W+2] == '0) && (paddr[1:0] == 2'h0)
                   && (idx < PFSM_IDX_W'(PFSM_NUM_REGS));
   assign setup_phase = psel && !penable;
   assign write_take = psel && penable && pready_q && pwrite && mapped && pstrb[0];
   assign wr_mask = reg_mask(idx);

   // Selector storage
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < PFSM_NUM_REGS; i++) begin
            cfg_q[i] <= PFSM_RESET_VAL;
         end
      end else if (clk_en && write_take) begin
         cfg_q[idx] <= pwdata[7:0] & wr_mask;
      end
   end

   // Answer prepared in setup, ready in access
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (clk_en) begin
         pready_q <= setup_phase;
         pslverr_q <= setup_phase && !mapped;
         prdata_q <= (setup_phase && mapped && !pwrite) ? {24'h000000, cfg_q[idx]} : '0;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ==========================================================
   // Pin synchronisers
   logic [71:0] pins_s;
   logic [7:0] pa;
   logic [7:0] pb;
   logic [7:0] pc;
   logic [7:0] pd;
   logic [7:0] pe;
   logic [7:0] pf;
   logic [7:0] pg;
   logic [7:0] ph;
   logic [7:0] pj;

   pfsm_pin_sync #(
      .WIDTH(72)
   ) u_pin_sync (
      .clk(sys_clk),
      .rst_n(rst_n),
      .ce(clk_en),
      .async_in({port_j_in, port_h_in, port_g_in, port_f_in, port_e_in,
                 port_d_in, port_c_in, port_b_in, port_a_in}),
      .sync_out(pins_s)
   );

   // Split synchronised ports
   assign pa = pins_s[7:0];
   assign pb = pins_s[15:8];
   assign pc = pins_s[23:16];
   assign pd = pins_s[31:24];
   assign pe = pins_s[39:32];
   assign pf = pins_s[47:40];
   assign pg = pins_s[55:48];
   assign ph = pins_s[63:56];
   assign pj = pins_s[71:64];

   // ==========================================================
   // Input source routing
   logic [7:0] tclk_r;
   logic [7:0] tcap_r;
   logic [7:0] ser_r;
   logic [7:0] ext_r;
   logic [7:0] uart_r;
   logic [31:0] rt_sel;
   logic [31:0] rt_src0;
   logic [31:0] rt_src1;
   logic [31:0] routed;

   assign tclk_r = cfg_q[PFSM_IDX_TCLK_SRC];
   assign tcap_r = cfg_q[PFSM_IDX_TCAP_SRC];
   assign ser_r = cfg_q[PFSM_IDX_SER_SRC];
   assign ext_r = cfg_q[PFSM_IDX_EXT_SRC];
   assign uart_r = cfg_q[PFSM_IDX_UART_SRC];

   // Order: uart 2..0, irq 3..0, serial cs/data/clk, st cap, st clk, pt cap 7..0, pt clk 7..0
   // periodic clocks
   assign rt_sel = {uart_r[2:0], ser_r[3:0], ser_r[6:4], tcap_r[2:0], tclk_r[2:0],
                    ext_r[3:0], tcap_r[6:3], ext_r[7:4], tclk_r[6:3]};

   assign rt_src0 = {pb[0], pd[1], pa[6], pa[5], pa[4], pa[3], pa[1], pa[1], pa[4], pa[5],
                     pd[6], pd[0], pc[6], pf[6], pd[1], pc[7],
                     pd[3], pc[7], pc[5], pc[3], pd[4], pd[2], pc[4], pc[2],
                     ph[5], ph[4], ph[3], ph[2], pd[5], pd[3], pc[5], pc[3]};
   assign rt_src1 = {pg[0], pf[6], pd[4], pc[7], pd[0], pa[7], pa[6], pf[0], pf[2], pf[3],
                     pf[7], pb[6], pe[1], pb[0], pb[7], pe[0],
                     ph[7], ph[6], ph[1], ph[0], pb[2], pb[3], pe[3], pf[5],
                     pj[4], pj[5], pj[6], pj[7], pb[1], pb[2], pe[2], pf[4]};

   pfsm_src_route #(
      .N(PFSM_NUM_ROUTES)
   ) u_src_route (
      .clk(sys_clk),
      .rst_n(rst_n),
      .ce(clk_en),
      .sel(rt_sel),
      .src0(rt_src0),
      .src1(rt_src1),
      .routed(routed)
   );

   // Split routed inputs
   assign periodic_timer_clock_in = routed[7:0];
   assign periodic_timer_capture_in = routed[15:8];
   assign standard_timer_clock_in = routed[18:16];
   assign standard_timer_capture_in = routed[21:19];
   assign serial_clock_in = routed[22];
   assign serial_data_in = routed[23];
   assign serial_select_in = routed[24];
   assign ext_irq_in = routed[28:25];
   assign uart_receive_in = routed[31:29];

   // ==========================================================
   // Pin function decode, port H
   logic [15:0] ph_codes;
   logic [7:0] ph_alt_out;
   logic [7:0] ph_out_q;
   logic [7:0] ph_oe_q;
   logic [7:0] ph_seg_q;
   logic [1:0] ph_an_q;

   // PH3/PH2 belong to another selector, kept as GPIO
   assign ph_codes = {cfg_q[PFSM_IDX_PH_HIGH], 4'h0, cfg_q[PFSM_IDX_PH_LOW][3:0]};
   // Timer outputs on pins 7,6,1,0
   assign ph_alt_out = {periodic_timer7_out, periodic_timer6_out, 4'h0, periodic_timer5_out, periodic_timer4_out};

   for (genvar i = 0; i < 8; i++) begin : g_ph
      logic [1:0] code;
      logic gpio;
      logic alt;
      assign code = ph_codes[2*i+1:2*i];
      assign gpio = fn_is_gpio(code, 1'b0);
      assign alt = (code == PFSM_FN_ALT);
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            ph_out_q[i] <= 1'b0;
            ph_oe_q[i] <= 1'b0;
            ph_seg_q[i] <= 1'b0;
         end else if (clk_en) begin
            ph_out_q[i] <= gpio ? gpio_h_out[i] : (alt && ph_alt_out[i]);
            ph_oe_q[i] <= gpio ? gpio_h_oe[i] : (alt && (i != 4) && (i != 5));
            ph_seg_q[i] <= (code == PFSM_FN_SEG);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_an_q <= 2'h0;
      end else if (clk_en) begin
         ph_an_q <= {ph_codes[11:10] == PFSM_FN_ALT, ph_codes[9:8] == PFSM_FN_ALT};
      end
   end

   assign ph_pin_out = ph_out_q;
   assign ph_pin_oe = ph_oe_q;
   assign ph_lcd_seg_en = ph_seg_q;
   assign analog_channel_15_en = ph_an_q[1];
   assign analog_channel_14_en = ph_an_q[0];

   // ==========================================================
   // Pin function decode, port J
   logic [15:0] pj_codes;
   logic [7:0] pj_out_q;
   logic [7:0] pj_oe_q;
   logic [7:0] pj_seg_q;
   logic [3:0] pj_com_q;

   assign pj_codes = {cfg_q[PFSM_IDX_PJ_HIGH], cfg_q[PFSM_IDX_PJ_LOW]};

   for (genvar i = 0; i < 8; i++) begin : g_pj
      logic [1:0] code;
      logic gpio;
      assign code = pj_codes[2*i+1:2*i];
      // upper pins keep GPIO on code 10
      assign gpio = fn_is_gpio(code, i >= 4);
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            pj_out_q[i] <= 1'b0;
            pj_oe_q[i] <= 1'b0;
            pj_seg_q[i] <= 1'b0;
         end else if (clk_en) begin
            pj_out_q[i] <= gpio && gpio_j_out[i];
            pj_oe_q[i] <= gpio && gpio_j_oe[i];
            pj_seg_q[i] <= (code == PFSM_FN_SEG);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pj_com_q <= 4'h0;
      end else if (clk_en) begin
         pj_com_q <= {pj_codes[7:6] == PFSM_FN_ALT, pj_codes[5:4] == PFSM_FN_ALT,
                      pj_codes[3:2] == PFSM_FN_ALT, pj_codes[1:0] == PFSM_FN_ALT};
      end
   end

   assign pj_pin_out = pj_out_q;
   assign pj_pin_oe = pj_oe_q;
   assign pj_lcd_seg_en = pj_seg_q;
   assign pj_lcd_common_en = pj_com_q;
endmodule : pfsm_top
`default_nettype wire

// ==== logic/pfsm_pkg.sv ====
`default_nettype none
// ==========================================================
// Shared constants for the pin function and source mux
package pfsm_pkg;
   // APB address and data widths
   localparam int unsigned PFSM_ADDR_W = 12;
   localparam int unsigned PFSM_DATA_W = 32;
   localparam int unsigned PFSM_REG_W = 8;
   localparam int unsigned PFSM_NUM_REGS = 9;
   localparam int unsigned PFSM_IDX_W = 4;
   // Register byte offsets
   localparam logic [11:0] PFSM_OFF_PH_LOW = 12'h000;
   localparam logic [11:0] PFSM_OFF_PH_HIGH = 12'h004;
   localparam logic [11:0] PFSM_OFF_PJ_LOW = 12'h008;
   localparam logic [11:0] PFSM_OFF_PJ_HIGH = 12'h00C;
   localparam logic [11:0] PFSM_OFF_TCLK_SRC = 12'h010;
   localparam logic [11:0] PFSM_OFF_TCAP_SRC = 12'h014;
   localparam logic [11:0] PFSM_OFF_SER_SRC = 12'h018;
   localparam logic [11:0] PFSM_OFF_EXT_SRC = 12'h01C;
   localparam logic [11:0] PFSM_OFF_UART_SRC = 12'h020;
   // Register indices (byte offset divided by four)
   localparam logic [3:0] PFSM_IDX_PH_LOW = 4'h0;
   localparam logic [3:0] PFSM_IDX_PH_HIGH = 4'h1;
   localparam logic [3:0] PFSM_IDX_PJ_LOW = 4'h2;
   localparam logic [3:0] PFSM_IDX_PJ_HIGH = 4'h3;
   localparam logic [3:0] PFSM_IDX_TCLK_SRC = 4'h4;
   localparam logic [3:0] PFSM_IDX_TCAP_SRC = 4'h5;
   localparam logic [3:0] PFSM_IDX_SER_SRC = 4'h6;
   localparam logic [3:0] PFSM_IDX_EXT_SRC = 4'h7;
   localparam logic [3:0] PFSM_IDX_UART_SRC = 4'h8;
   // Value of every selector after reset
   localparam logic [7:0] PFSM_RESET_VAL = 8'h00;
   // Implemented-bit masks
   localparam logic [7:0] PFSM_MASK_ALL = 8'hFF;
   localparam logic [7:0] PFSM_MASK_NONE = 8'h00;
   localparam logic [7:0] PFSM_MASK_PH_LOW = 8'h0F;
   localparam logic [7:0] PFSM_MASK_PJ_HIGH_SMALL = 8'hF0;
   localparam logic [7:0] PFSM_MASK_SRC_7BIT = 8'h7F;
   localparam logic [7:0] PFSM_MASK_UART_SMALL = 8'h03;
   localparam logic [7:0] PFSM_MASK_UART_FULL = 8'h07;
   // Two-bit pin function codes
   localparam logic [1:0] PFSM_FN_ALT = 2'h2;
   localparam logic [1:0] PFSM_FN_SEG = 2'h3;
   // Device variants, smallest first
   localparam int unsigned PFSM_VAR_SMALL = 0;
   localparam int unsigned PFSM_VAR_UART2 = 2;
   // Number of routed peripheral inputs
   localparam int unsigned PFSM_NUM_ROUTES = 32;
endpackage : pfsm_pkg
`default_nettype wire

// ==== logic/pfsm_pin_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Two-flop synchroniser for package pin levels
module pfsm_pin_sync #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and control
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Pin levels in, synchronised levels out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // Only the second stage reads the first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce) begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule : pfsm_pin_sync
`default_nettype wire

// ==== logic/pfsm_src_route.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Per-input choice between two source pins, registered
module pfsm_src_route #(
   parameter int unsigned N = 32
) (
   // Clock and control
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Selector bits and the two candidate pins
   input wire logic [N-1:0] sel,
   input wire logic [N-1:0] src0,
   input wire logic [N-1:0] src1,
   // Routed peripheral inputs
   output logic [N-1:0] routed
);
   logic [N-1:0] pick;
   logic [N-1:0] routed_q;

   // Only the chosen pin reaches each input
   for (genvar g = 0; g < N; g++) begin : g_pick
      assign pick[g] = sel[g] ? src1[g] : src0[g];
   end

   // Output register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         routed_q <= '0;
      end else if (ce) begin
         routed_q <= pick;
      end
   end

   assign routed = routed_q;
endmodule : pfsm_src_route
`default_nettype wire

// ==== verif/pfsm_pin_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Package pins and timer outputs seen by the mux
module pfsm_pin_model (
   // Clock and requested pin levels
   input wire logic clk,
   input wire logic [71:0] want,
   // Pin levels and timer outputs
   output logic [71:0] pins,
   output logic [3:0] tmr
);
   // Known levels from time zero
   initial begin
      pins = 72'h0;
      tmr = 4'h0;
   end
   // Pins move just after the edge; timer outputs count up as one 4-bit value every cycle
   always @(posedge clk) begin
      pins <= want;
      tmr <= tmr + 4'h1;
   end
endmodule : pfsm_pin_model
`default_nettype wire

// ==== verif/pfsm_top_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Port-level checks for the pin function and source mux
module pfsm_top_checker
   import pfsm_pkg::*;
(
   // Clock, reset and APB
   input wire logic sys_clk, input wire logic reset_n, input wire logic [PFSM_ADDR_W-1:0] paddr,
   input wire logic psel, input wire logic penable, input wire logic pwrite,
   input wire logic [PFSM_DATA_W-1:0] pwdata, input wire logic [3:0] pstrb,
   input wire logic [PFSM_DATA_W-1:0] prdata, input wire logic pready, input wire logic pslverr,
   // Pins and timer output
   input wire logic [7:0] port_b_in, input wire logic [7:0] port_d_in, input wire logic periodic_timer5_out,
   input wire logic [7:0] gpio_j_out, input wire logic [7:0] gpio_j_oe,
   // Pin function outputs
   input wire logic [7:0] ph_pin_out, input wire logic [7:0] ph_pin_oe, input wire logic [7:0] ph_lcd_seg_en,
   input wire logic analog_channel_14_en, input wire logic analog_channel_15_en,
   input wire logic [7:0] pj_pin_out, input wire logic [7:0] pj_pin_oe,
   input wire logic [7:0] pj_lcd_seg_en, input wire logic [3:0] pj_lcd_common_en,
   // Routed timer clocks
   input wire logic [7:0] periodic_timer_clock_in
);
   logic [7:0] sh_q [9];
   // Decode of completed transfers
   wire acc = psel && penable && pready;
   wire hit = paddr[11:6] == 6'h00 && paddr[5:2] < 4'h9 && paddr[1:0] == 2'h0;
   wire wr = acc && pwrite && pstrb[0] && hit;
   // Field code matches per two-bit field
   function automatic logic [3:0] code_of(input logic [7:0] r, input logic [1:0] c);
      code_of = {r[7:6] == c, r[5:4] == c, r[3:2] == c, r[1:0] == c};
   endfunction : code_of
   // Expected pin function enables
   wire [3:0] ph_alt = code_of(sh_q[1], 2'h2);
   wire [3:0] ph_alt_low = code_of({4'h0, sh_q[0][3:0]}, 2'h2);
   wire [7:0] ph_seg = {code_of(sh_q[1], 2'h3), code_of({4'h0, sh_q[0][3:0]}, 2'h3)};
   wire [7:0] pj_seg = {code_of(sh_q[3], 2'h3), code_of(sh_q[2], 2'h3)};
   wire [3:0] pj_com = code_of(sh_q[2], 2'h2);
   wire [7:0] pj_gpio = ~(pj_seg | {4'h0, pj_com});
   wire [15:0] pj_drv = {pj_gpio & gpio_j_out, pj_gpio & gpio_j_oe};
   // Shadow of selector writes
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 9; i++) sh_q[i] <= 8'h00;
      end else if (wr) begin
         sh_q[paddr[5:2]] <= pwdata[7:0];
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // One access cycle per transfer
   a_ready_one_cycle: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not a single cycle after setup");
   a_unmapped_err: assert property (acc |-> pslverr == !hit)
      else $error("pslverr does not match address decode");
   a_src_bit7_zero: assert property (acc && !pwrite && paddr inside {12'h010, 12'h014, 12'h018} |-> !prdata[7])
      else $error("source selector bit 7 read as one");
   a_reset_clear: assert property ($rose(reset_n) |-> ph_lcd_seg_en == 8'h00 && pj_lcd_seg_en == 8'h00)
      else $error("outputs not clear after reset");
   a_ph_seg_code: assert property (ph_lcd_seg_en == $past(ph_seg))
      else $error("port H segment enable wrong");
   a_ph_analog: assert property ({analog_channel_15_en, analog_channel_14_en} == $past(ph_alt[1:0]))
      else $error("analog channel enable wrong");
   a_pj_seg_code: assert property (pj_lcd_seg_en == $past(pj_seg))
      else $error("port J segment enable wrong");
   a_pj_common: assert property (pj_lcd_common_en == $past(pj_com))
      else $error("port J common enable wrong");
   a_pj_gpio_drive: assert property ({pj_pin_out, pj_pin_oe} == $past(pj_drv))
      else $error("port J GPIO drive wrong");
   a_ph1_timer: assert property ($past(ph_alt_low[1]) |-> ph_pin_oe[1] && ph_pin_out[1] == $past(periodic_timer5_out))
      else $error("timer output not driven on port H pin 1");
   a_route_ptclk3: assert property (periodic_timer_clock_in[3] ==
      ($past(sh_q[4][6]) ? $past(port_b_in[1], 3) : $past(port_d_in[5], 3)))
      else $error("timer clock 3 follows wrong pin");
endmodule : pfsm_top_checker

bind pfsm_top pfsm_top_checker pfsm_top_checker_inst (
   .sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .port_b_in(port_b_in), .port_d_in(port_d_in), .periodic_timer5_out(periodic_timer5_out),
   .gpio_j_out(gpio_j_out), .gpio_j_oe(gpio_j_oe), .pj_pin_out(pj_pin_out), .pj_pin_oe(pj_pin_oe),
   .ph_pin_out(ph_pin_out), .ph_pin_oe(ph_pin_oe), .ph_lcd_seg_en(ph_lcd_seg_en),
   .analog_channel_14_en(analog_channel_14_en), .analog_channel_15_en(analog_channel_15_en),
   .pj_lcd_seg_en(pj_lcd_seg_en), .pj_lcd_common_en(pj_lcd_common_en),
   .periodic_timer_clock_in(periodic_timer_clock_in)
);
`default_nettype wire

// ==== verif/test_pfsm_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Self-checking bench for the pin function and source mux
module test_pfsm_top
   import pfsm_pkg::*;
;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rt_chk = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [71:0] want = 72'h0;
   logic [31:0] gpio = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr;
   wire [71:0] pins;
   wire [3:0] tmr;
   wire [31:0] rt;
   logic [7:0] m [9];
   logic [33:0] aq [$];
   logic [31:0] rq [$];
   int p0 [32], p1 [32];
   int fails = 0, cmp_count = 0;
   // ==========================================================
   // Clock, pins and device
   always #10 sys_clk = ~sys_clk;
   pfsm_pin_model pfsm_pin_model_inst (.clk(sys_clk), .want(want), .pins(pins), .tmr(tmr));
   pfsm_top #(.VARIANT(3)) pfsm_top_inst (
      .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_a_in(pins[7:0]), .port_b_in(pins[15:8]), .port_c_in(pins[23:16]), .port_d_in(pins[31:24]),
      .port_e_in(pins[39:32]), .port_f_in(pins[47:40]), .port_g_in(pins[55:48]), .port_h_in(pins[63:56]),
      .port_j_in(pins[71:64]), .gpio_h_out(gpio[7:0]), .gpio_h_oe(gpio[15:8]), .gpio_j_out(gpio[23:16]),
      .gpio_j_oe(gpio[31:24]), .periodic_timer4_out(tmr[0]), .periodic_timer5_out(tmr[1]),
      .periodic_timer6_out(tmr[2]), .periodic_timer7_out(tmr[3]), .ph_pin_out(), .ph_pin_oe(),
      .ph_lcd_seg_en(), .analog_channel_14_en(), .analog_channel_15_en(), .pj_pin_out(), .pj_pin_oe(),
      .pj_lcd_seg_en(), .pj_lcd_common_en(), .periodic_timer_clock_in(rt[7:0]),
      .periodic_timer_capture_in(rt[15:8]), .standard_timer_clock_in(rt[18:16]),
      .standard_timer_capture_in(rt[21:19]), .serial_select_in(rt[24]), .serial_data_in(rt[23]),
      .serial_clock_in(rt[22]), .ext_irq_in(rt[28:25]), .uart_receive_in(rt[31:29])
   );
   // ==========================================================
   // Compare tasks and verdict
   task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("Error apb_response expected %h seen %h", e, g);
      end
   endtask : cmp_rd
   task automatic cmp_rt(input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("Error routed_inputs expected %h seen %h", e, g);
      end
   endtask : cmp_rt
   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   // ==========================================================
   // APB master with expectation notes
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [7:0] e, input logic err);
      aq.push_back({~w, err, 24'h0, e});
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [7:0] mask(input int i);
      mask = (i == 0) ? PFSM_MASK_PH_LOW : (i inside {4, 5, 6}) ? PFSM_MASK_SRC_7BIT :
             (i == 8) ? PFSM_MASK_UART_FULL : PFSM_MASK_ALL;
   endfunction : mask
   task automatic wr(input int i, input logic [7:0] d, input logic [3:0] s);
      if (s[0]) m[i] = d & mask(i);
      apb(1'b1, 12'(i * 4), d, s, 8'h00, 1'b0);
   endtask : wr
   task automatic rd(input int i);
      apb(1'b0, 12'(i * 4), 8'h00, 4'h0, m[i], 1'b0);
   endtask : rd
   // Expected routed inputs from selectors and pin levels
   function automatic logic [31:0] route_exp();
      logic [31:0] sel;
      logic [31:0] r;
      sel = {m[8][2:0], m[6][3:0], m[6][6:4], m[5][2:0], m[4][2:0], m[7][3:0], m[5][6:3], m[7][7:4], m[4][6:3]};
      for (int n = 0; n < 32; n++) r[n] = sel[n] ? want[p1[n]] : want[p0[n]];
      return r;
   endfunction : route_exp
   task automatic chk_route();
      repeat (6) @(posedge sys_clk);
      rq.push_back(route_exp());
      rt_chk <= 1'b1;
      @(posedge sys_clk);
      rt_chk <= 1'b0;
   endtask : chk_route
   // Result watcher takes the oldest note
   always @(posedge sys_clk) begin
      if (psel && penable && pready === 1'b1 && aq.size() > 0) begin
         cmp_rd(aq[0], {aq[0][33], pslverr, aq[0][33] ? prdata : aq[0][31:0]});
         void'(aq.pop_front());
      end
      if (rt_chk && rq.size() > 0) begin
         cmp_rt(rq[0], rt);
         void'(rq.pop_front());
      end
   end
   // Watchdog
   initial begin
      #400000;
      fails++;
      final_report();
   end
   // ==========================================================
   // Test sequence
   initial begin
      p0 = '{19, 21, 27, 29, 58, 59, 60, 61, 18, 20, 26, 28, 19, 21, 23, 27,
             23, 25, 46, 22, 24, 30, 5, 4, 1, 1, 3, 4, 5, 6, 25, 8};
      p1 = '{44, 34, 10, 9, 71, 70, 69, 68, 45, 35, 11, 10, 56, 57, 62, 63,
             32, 15, 8, 33, 14, 47, 43, 42, 40, 6, 7, 24, 23, 28, 46, 48};
      for (int i = 0; i < 9; i++) m[i] = 8'h00;
      void'($urandom(32'hE0E6));
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      for (int i = 0; i < 9; i++) rd(i);
      $display("Test reset values done");
      for (int i = 0; i < 9; i++) wr(i, 8'hFF, 4'hF);
      for (int i = 0; i < 9; i++) rd(i);
      $display("Test implemented bits done");
      // Strobe off and unmapped places change nothing
      wr(1, 8'h00, 4'h0);
      apb(1'b1, 12'h005, 8'h00, 4'hF, 8'h00, 1'b1);
      apb(1'b0, 12'h024, 8'h00, 4'h0, 8'h00, 1'b1);
      rd(1);
      $display("Test refused writes done");
      for (int c = 0; c < 4; c++) begin
         for (int i = 0; i < 4; i++) wr(i, {4{2'(c)}}, 4'h1);
         gpio <= $urandom();
         for (int i = 0; i < 4; i++) rd(i);
      end
      $display("Test pin function codes done");
      for (int k = 0; k < 16; k++) begin
         want <= 72'({$urandom(), $urandom(), $urandom()});
         gpio <= $urandom();
         for (int i = 4; i < 9; i++) wr(i, 8'($urandom()), 4'h1);
         chk_route();
      end
      $display("Test input sources done");
      final_report();
   end
endmodule : test_pfsm_top
`default_nettype wire
